/* isp_boot_select_and_hex_framer.sv */
// Boot source select, fetch routing, autobaud UART and hex record framer.
// Assumes an APB master on i_clk; pins are asynchronous and synchronised.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`default_nettype none

module isp_boot_select_and_hex_framer
  import isp_boot_pkg::*;
#(
  parameter int BAUD_W = 16,
  parameter logic [15:0] FLASH_TOP = 16'h7FFF
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [APB_ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_device_reset_pin_n,
  input wire logic i_external_access_select_pin,
  input wire logic i_program_store_strobe_pin,
  input wire logic i_isp_rxd,
  output logic o_isp_txd,
  input wire logic i_fetch_valid,
  input wire logic [15:0] i_fetch_addr,
  output logic o_fetch_external,
  output logic o_api_entry,
  output logic o_boot_loader,
  output logic [15:0] o_boot_addr,
  output logic o_program_enable,
  output logic o_verify_enable,
  output logic o_data_valid,
  output logic [7:0] o_data_byte,
  output logic [15:0] o_data_addr,
  output logic o_record_done
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [4:0] hex_digit(input logic [7:0] c);
    hex_digit = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) begin
      hex_digit = {1'b1, c[3:0]};
    end else if ((c >= 8'h41 && c <= 8'h46) ||
                 (c >= 8'h61 && c <= 8'h66)) begin
      hex_digit = {1'b1, c[3:0] + 4'h9};
    end
  endfunction

  function automatic logic [7:0] msg_char(input logic is_x,
                                          input logic [1:0] idx);
    msg_char = CH_U;
    if (is_x) begin
      msg_char = (idx == 2'h0) ? CH_X : ((idx == 2'h1) ? CH_CR : CH_LF);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_reg, sync2_reg, sync3_reg, pin_flt_reg, pin_prev_reg;
  // Bits: 0 rxd, 1 access pin, 2 strobe pin, 3 reset pin
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      sync3_reg <= 4'hF;
      pin_flt_reg <= 4'hF;
      pin_prev_reg <= 4'hF;
    end else begin
      sync1_reg <= {i_device_reset_pin_n, i_program_store_strobe_pin,
                    i_external_access_select_pin, i_isp_rxd};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int i = 0; i < 4; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          pin_flt_reg[i] <= sync2_reg[i];
        end
      end
      pin_prev_reg <= pin_flt_reg;
    end
  end

  logic rxd, rxd_fall, rst_pin_fall;
  assign rxd = pin_flt_reg[0];
  assign rxd_fall = pin_prev_reg[0] & ~pin_flt_reg[0];
  assign rst_pin_fall = pin_prev_reg[3] & ~pin_flt_reg[3];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic boot_jump_fuse_reg;
  logic [7:0] user_boot_vector_reg, boot_status_byte_reg;
  logic [7:0] software_security_byte_reg;
  logic [ST_W-1:0] status_reg;
  logic [31:0] record_reg;
  logic [BAUD_W-1:0] bit_cyc_reg;
  rx_state_t rx_st_reg;
  logic frame_err_pulse, cksum_err_pulse, refused_pulse, record_ok_pulse;
  logic [7:0] len_reg, type_reg;
  logic [15:0] offset_reg;
  logic apb_write, apb_setup;
  logic [ST_W-1:0] st_set;

  assign apb_setup = i_psel & ~i_penable;
  assign apb_write = i_psel & i_penable & o_pready & i_pwrite;
  assign st_set = {record_ok_pulse, refused_pulse, cksum_err_pulse,
                   frame_err_pulse};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot_jump_fuse_reg <= RST_BOOT_JUMP_FUSE;
      user_boot_vector_reg <= RST_USER_BOOT_VECTOR;
      boot_status_byte_reg <= RST_BOOT_STATUS_BYTE;
      software_security_byte_reg <= RST_SOFTWARE_SECURITY_BYTE;
    end else if (apb_write) begin
      if (i_paddr == OFS_BOOT_CTRL) begin
        boot_jump_fuse_reg <= i_pwdata[0];
      end
      if (i_paddr == OFS_BOOT_VECT) begin
        user_boot_vector_reg <= i_pwdata[7:0];
        boot_status_byte_reg <= i_pwdata[15:8];
      end
      if (i_paddr == OFS_SECURITY) begin
        software_security_byte_reg <= i_pwdata[7:0];
      end
    end
  end

  // Sticky, write one to clear; a new event wins over the clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_reg <= '0;
    end else if (apb_write && i_paddr == OFS_STATUS) begin
      status_reg <= (status_reg & ~i_pwdata[ST_W-1:0]) | st_set;
    end else begin
      status_reg <= status_reg | st_set;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      record_reg <= '0;
    end else if (record_ok_pulse) begin
      record_reg <= {offset_reg, type_reg, len_reg};
    end
  end

  // Two cycle transfer: answer is ready in every access phase
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= apb_setup;
      o_pslverr <= 1'b0;
      o_prdata <= '0;
      if (apb_setup) begin
        unique case (i_paddr)
          OFS_BOOT_CTRL: o_prdata <= {31'h0, boot_jump_fuse_reg};
          OFS_BOOT_VECT: o_prdata <= {16'h0, boot_status_byte_reg,
                                      user_boot_vector_reg};
          OFS_SECURITY: o_prdata <= {24'h0, software_security_byte_reg};
          OFS_STATUS: o_prdata <= {{(32-ST_W-2){1'b0}}, o_boot_loader,
                                   (rx_st_reg != RX_AUTO_WAIT &&
                                    rx_st_reg != RX_AUTO_MEAS), status_reg};
          OFS_RECORD: o_prdata <= record_reg;
          OFS_BAUD: o_prdata <= {{(32-BAUD_W){1'b0}}, bit_cyc_reg};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Boot select and fetch routing
  // ----------------------------------------------------------------
  logic ea_latched_reg;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ea_latched_reg <= 1'b1;
      o_boot_loader <= 1'b0;
      o_boot_addr <= APP_BOOT_ADDR;
    end else if (rst_pin_fall) begin
      ea_latched_reg <= pin_flt_reg[1];
      if (pin_flt_reg[1] && !pin_flt_reg[2]) begin
        o_boot_loader <= 1'b1;
        o_boot_addr <= LOADER_BOOT_ADDR;
      end else if (boot_jump_fuse_reg) begin
        o_boot_loader <= 1'b0;
        o_boot_addr <= APP_BOOT_ADDR;
      end else if (boot_status_byte_reg == BOOT_STATUS_APP) begin
        o_boot_loader <= 1'b0;
        o_boot_addr <= APP_BOOT_ADDR;
      end else if (user_boot_vector_reg != NO_USER_LOADER) begin
        o_boot_loader <= 1'b0;
        o_boot_addr <= {user_boot_vector_reg, USER_LOADER_LOW};
      end else begin
        o_boot_loader <= 1'b1;
        o_boot_addr <= LOADER_BOOT_ADDR;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fetch_external <= 1'b0;
      o_api_entry <= 1'b0;
    end else begin
      o_fetch_external <= ~ea_latched_reg | (i_fetch_addr > FLASH_TOP);
      o_api_entry <= i_fetch_valid && (i_fetch_addr == API_ENTRY_ADDR);
    end
  end

  // ----------------------------------------------------------------
  // Lock bits
  // ----------------------------------------------------------------
  logic write_ok, verify_ok;
  assign write_ok = software_security_byte_reg[BIT_WRITE_LOCK] &
                    software_security_byte_reg[BIT_VERIFY_LOCK];
  assign verify_ok = software_security_byte_reg[BIT_VERIFY_LOCK];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_program_enable <= 1'b1;
      o_verify_enable <= 1'b1;
    end else begin
      o_program_enable <= write_ok;
      o_verify_enable <= verify_ok;
    end
  end

  // ----------------------------------------------------------------
  // Autobaud receiver
  // ----------------------------------------------------------------
  logic [BAUD_W-1:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_shift_reg;
  logic rx_valid_reg, send_u_reg, stop_err_reg;
  logic rx_bit_end;
  assign rx_bit_end = (rx_cnt_reg == bit_cyc_reg - 1'b1);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_st_reg <= RX_AUTO_WAIT;
      rx_cnt_reg <= '0;
      rx_idx_reg <= 4'h0;
      rx_shift_reg <= 8'h00;
      bit_cyc_reg <= '1;
      rx_valid_reg <= 1'b0;
      send_u_reg <= 1'b0;
      stop_err_reg <= 1'b0;
    end else begin
      rx_valid_reg <= 1'b0;
      send_u_reg <= 1'b0;
      stop_err_reg <= 1'b0;
      rx_cnt_reg <= rx_cnt_reg + 1'b1;
      unique case (rx_st_reg)
        RX_AUTO_WAIT: if (rxd_fall) begin
          rx_cnt_reg <= {{(BAUD_W-1){1'b0}}, 1'b1};
          rx_st_reg <= RX_AUTO_MEAS;
        end
        RX_AUTO_MEAS: if (rxd) begin
          bit_cyc_reg <= rx_cnt_reg;
          rx_cnt_reg <= '0;
          rx_idx_reg <= 4'h0;
          send_u_reg <= 1'b1;
          rx_st_reg <= RX_SKIP;
        end else if (&rx_cnt_reg) begin
          rx_st_reg <= RX_AUTO_WAIT;
        end
        // Skip the rest of the opening character
        RX_SKIP: if (rx_bit_end) begin
          rx_cnt_reg <= '0;
          rx_idx_reg <= rx_idx_reg + 1'b1;
          if (rx_idx_reg == 4'h7) begin
            rx_st_reg <= RX_IDLE;
          end
        end
        RX_IDLE: if (rxd_fall) begin
          rx_cnt_reg <= '0;
          rx_st_reg <= RX_START;
        end
        // Mid start bit check rejects glitches
        RX_START: if (rx_cnt_reg == (bit_cyc_reg >> 1)) begin
          rx_cnt_reg <= '0;
          rx_idx_reg <= 4'h0;
          rx_st_reg <= rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_bit_end) begin
          rx_cnt_reg <= '0;
          rx_shift_reg <= {rxd, rx_shift_reg[7:1]};
          rx_idx_reg <= rx_idx_reg + 1'b1;
          if (rx_idx_reg == 4'h7) begin
            rx_st_reg <= RX_STOP;
          end
        end
        RX_STOP: if (rx_bit_end) begin
          rx_valid_reg <= rxd;
          stop_err_reg <= ~rxd;
          rx_st_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmitter for U echo and X reply
  // ----------------------------------------------------------------
  tx_state_t tx_st_reg;
  logic [BAUD_W-1:0] tx_cnt_reg;
  logic [2:0] tx_bit_reg;
  logic [1:0] tx_chr_reg;
  logic tx_is_x_reg, send_x_reg;
  logic [7:0] tx_shift_reg;
  logic tx_bit_end;
  assign tx_bit_end = (tx_cnt_reg == bit_cyc_reg - 1'b1);

  // Requests while busy are dropped; replies never overlap in practice
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_st_reg <= TX_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= 3'h0;
      tx_chr_reg <= 2'h0;
      tx_is_x_reg <= 1'b0;
      tx_shift_reg <= 8'hFF;
      o_isp_txd <= 1'b1;
    end else begin
      tx_cnt_reg <= tx_bit_end ? '0 : tx_cnt_reg + 1'b1;
      unique case (tx_st_reg)
        TX_IDLE: begin
          o_isp_txd <= 1'b1;
          tx_cnt_reg <= '0;
          if (send_u_reg || send_x_reg) begin
            tx_is_x_reg <= send_x_reg;
            tx_chr_reg <= 2'h0;
            tx_shift_reg <= msg_char(send_x_reg, 2'h0);
            o_isp_txd <= 1'b0;
            tx_st_reg <= TX_START;
          end
        end
        TX_START: if (tx_bit_end) begin
          o_isp_txd <= tx_shift_reg[0];
          tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
          tx_bit_reg <= 3'h0;
          tx_st_reg <= TX_DATA;
        end
        TX_DATA: if (tx_bit_end) begin
          tx_bit_reg <= tx_bit_reg + 1'b1;
          o_isp_txd <= (tx_bit_reg == 3'h7) ? 1'b1 : tx_shift_reg[0];
          tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
          if (tx_bit_reg == 3'h7) begin
            tx_st_reg <= TX_STOP;
          end
        end
        TX_STOP: if (tx_bit_end) begin
          tx_chr_reg <= tx_chr_reg + 1'b1;
          if (tx_chr_reg + 1'b1 == (tx_is_x_reg ? MSG_LEN_X : MSG_LEN_U)) begin
            tx_st_reg <= TX_IDLE;
          end else begin
            tx_shift_reg <= msg_char(tx_is_x_reg, tx_chr_reg + 1'b1);
            o_isp_txd <= 1'b0;
            tx_st_reg <= TX_START;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Hex record parser
  // ----------------------------------------------------------------
  parse_state_t p_st_reg;
  logic have_hi_reg;
  logic [3:0] hi_reg;
  logic [8:0] byte_cnt_reg;
  logic [7:0] sum_reg;
  logic [4:0] dig;
  logic [7:0] dbyte;
  assign dig = hex_digit(rx_shift_reg);
  assign dbyte = {hi_reg, dig[3:0]};

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      p_st_reg <= P_HUNT;
      have_hi_reg <= 1'b0;
      hi_reg <= 4'h0;
      byte_cnt_reg <= '0;
      sum_reg <= 8'h00;
      len_reg <= 8'h00;
      type_reg <= 8'h00;
      offset_reg <= 16'h0000;
      frame_err_pulse <= 1'b0;
      cksum_err_pulse <= 1'b0;
      refused_pulse <= 1'b0;
      record_ok_pulse <= 1'b0;
      send_x_reg <= 1'b0;
      o_data_valid <= 1'b0;
      o_data_byte <= 8'h00;
      o_data_addr <= 16'h0000;
      o_record_done <= 1'b0;
    end else begin
      frame_err_pulse <= stop_err_reg;
      cksum_err_pulse <= 1'b0;
      refused_pulse <= 1'b0;
      record_ok_pulse <= 1'b0;
      send_x_reg <= 1'b0;
      o_data_valid <= 1'b0;
      o_record_done <= 1'b0;
      if (rx_valid_reg) begin
        if (rx_shift_reg == CH_COLON) begin
          p_st_reg <= P_FIELD;
          have_hi_reg <= 1'b0;
          byte_cnt_reg <= '0;
          sum_reg <= 8'h00;
        end else if (p_st_reg == P_FIELD) begin
          if (!dig[4]) begin
            frame_err_pulse <= 1'b1;
            p_st_reg <= P_HUNT;
          end else if (!have_hi_reg) begin
            hi_reg <= dig[3:0];
            have_hi_reg <= 1'b1;
          end else begin
            have_hi_reg <= 1'b0;
            sum_reg <= sum_reg + dbyte;
            byte_cnt_reg <= byte_cnt_reg + 1'b1;
            if (byte_cnt_reg == 9'h000) begin
              len_reg <= dbyte;
            end else if (byte_cnt_reg == 9'h001) begin
              offset_reg[15:8] <= dbyte;
            end else if (byte_cnt_reg == 9'h002) begin
              offset_reg[7:0] <= dbyte;
            end else if (byte_cnt_reg == 9'h003) begin
              type_reg <= dbyte;
            end else if (byte_cnt_reg < HDR_BYTES + {1'b0, len_reg}) begin
              o_data_byte <= dbyte;
              o_data_addr <= 16'h0000;
              if (type_reg == REC_TYPE_DATA) begin
                o_data_addr <= offset_reg +
                               {8'h00, byte_cnt_reg[7:0] - HDR_BYTES[7:0]};
                o_data_valid <= write_ok;
                refused_pulse <= ~write_ok;
              end else begin
                o_data_valid <= 1'b1;
              end
            end else begin
              p_st_reg <= P_HUNT;
              o_record_done <= 1'b1;
              if (sum_reg + dbyte == 8'h00) begin
                record_ok_pulse <= 1'b1;
              end else begin
                cksum_err_pulse <= 1'b1;
                send_x_reg <= 1'b1;
              end
            end
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

/* isp_boot_pkg.sv */
// Constants and state types for the boot select and hex record framer.
// Assumes a single 125 MHz clock domain and an APB register bus.
`default_nettype none

package isp_boot_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] OFS_BOOT_CTRL = 12'h000;
  localparam logic [11:0] OFS_BOOT_VECT = 12'h004;
  localparam logic [11:0] OFS_SECURITY = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_RECORD = 12'h010;
  localparam logic [11:0] OFS_BAUD = 12'h014;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic RST_BOOT_JUMP_FUSE = 1'b0;
  localparam logic [7:0] RST_USER_BOOT_VECTOR = 8'hFC;
  localparam logic [7:0] RST_BOOT_STATUS_BYTE = 8'hFF;
  localparam logic [7:0] RST_SOFTWARE_SECURITY_BYTE = 8'hFF;
  localparam int BIT_WRITE_LOCK = 0;
  localparam int BIT_VERIFY_LOCK = 1;
  localparam int ST_FRAME_ERR = 0;
  localparam int ST_CKSUM_ERR = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_RECORD_OK = 3;
  localparam int ST_W = 4;

  // ----------------------------------------------------------------
  // Addresses and characters
  // ----------------------------------------------------------------
  localparam logic [15:0] LOADER_BOOT_ADDR = 16'hF800;
  localparam logic [15:0] APP_BOOT_ADDR = 16'h0000;
  localparam logic [15:0] API_ENTRY_ADDR = 16'hFFF0;
  localparam logic [7:0] NO_USER_LOADER = 8'hFC;
  localparam logic [7:0] BOOT_STATUS_APP = 8'h00;
  localparam logic [7:0] USER_LOADER_LOW = 8'h00;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_U = 8'h55;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] REC_TYPE_DATA = 8'h00;
  localparam logic [8:0] HDR_BYTES = 9'h004;
  localparam logic [1:0] MSG_LEN_U = 2'h1;
  localparam logic [1:0] MSG_LEN_X = 2'h3;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    RX_AUTO_WAIT = 7'h01,
    RX_AUTO_MEAS = 7'h02,
    RX_SKIP = 7'h04,
    RX_IDLE = 7'h08,
    RX_START = 7'h10,
    RX_DATA = 7'h20,
    RX_STOP = 7'h40
  } rx_state_t;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } tx_state_t;

  typedef enum logic [1:0] {
    P_HUNT = 2'h1,
    P_FIELD = 2'h2
  } parse_state_t;

endpackage

`default_nettype wire

/* isp_framer_sva.sv */
// Port checker for the boot select and hex framer.
// Assumes a bind to the top module and one clock domain.
`default_nettype none
module isp_framer_sva import isp_boot_pkg::*; #(
  parameter logic [15:0] FLASH_TOP = 16'h7FFF
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_fetch_valid,
  input wire logic [15:0] i_fetch_addr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_fetch_external,
  input wire logic o_api_entry,
  input wire logic o_program_enable,
  input wire logic o_verify_enable,
  input wire logic o_record_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_ready_after_setup:
    assert property (i_psel && !i_penable |=> o_pready) else $error("ready");
  a_err_with_ready:
    assert property (o_pslverr |-> o_pready) else $error("slverr");
  a_rdata_idle:
    assert property (!o_pready |-> o_prdata == 32'h0) else $error("prdata");
  a_api_entry_hit:
    assert property (i_fetch_valid && i_fetch_addr == API_ENTRY_ADDR
      |=> o_api_entry) else $error("api missed");
  a_api_entry_miss:
    assert property (!(i_fetch_valid && i_fetch_addr == API_ENTRY_ADDR)
      |=> !o_api_entry) else $error("api spurious");
  a_fetch_above_top:
    assert property (i_fetch_addr > FLASH_TOP |=> o_fetch_external)
      else $error("fetch internal");
  a_verify_lock_prog:
    assert property (!o_verify_enable |-> !o_program_enable)
      else $error("lock");
  a_done_pulse:
    assert property (o_record_done |=> !o_record_done) else $error("done");
endmodule
bind isp_boot_select_and_hex_framer isp_framer_sva
  #(.FLASH_TOP(FLASH_TOP)) u_sva (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_fetch_valid(i_fetch_valid),
  .i_fetch_addr(i_fetch_addr), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_fetch_external(o_fetch_external),
  .o_api_entry(o_api_entry), .o_program_enable(o_program_enable),
  .o_verify_enable(o_verify_enable), .o_record_done(o_record_done));
`default_nettype wire

/* host_uart.sv */
// Host programmer model: 8N1 sender and receiver at a fixed bit time.
// Assumes the bench clock; the line idles high between characters.
`default_nettype none
module host_uart #(parameter int BIT = 16) (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$];
  logic [7:0] sh;
  initial o_rxd = 1'b1;
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_rxd <= f[i];
      repeat (BIT - 1) @(posedge i_clk);
    end
  endtask
  // Mid-bit sampling tolerates the echo's sync skew
  always begin
    @(negedge i_txd);
    repeat (BIT + BIT / 2) @(posedge i_clk);
    for (int i = 0; i < 8; i++) begin
      sh[i] = i_txd;
      repeat (BIT) @(posedge i_clk);
    end
    got.push_back(sh);
  end
endmodule
`default_nettype wire

/* test_isp_boot_select_and_hex_framer.sv */
// Bench for the boot select and hex framer: APB and host UART tests.
// Assumes the package, the design, the host model and the checker.
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  fail_count++; $display("Error %0t %h %h", $time, a, b); end end
module test_isp_boot_select_and_hex_framer import isp_boot_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_arst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
  logic i_pwrite = 1'b0, o_pready, o_pslverr, err, i_isp_rxd, o_isp_txd;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, r;
  // strobe pin high at power on
  logic i_device_reset_pin_n = 1'b1, i_program_store_strobe_pin = 1'b1;
  logic i_external_access_select_pin = 1'b1, i_fetch_valid = 1'b0;
  logic o_fetch_external, o_api_entry, o_boot_loader, o_record_done;
  logic o_program_enable, o_verify_enable, o_data_valid;
  logic [15:0] i_fetch_addr = 16'h0, o_boot_addr, o_data_addr, da[$];
  logic [7:0] o_data_byte, db[$];
  logic [43:0] bt[5] = '{44'h101FF12F800, 44'h111FF120000,
    44'h010FF121200, 44'h01000FC0000, 44'h110FFFCF800};
  int fail_count = 0, total_checks = 0;
  isp_boot_select_and_hex_framer u_dut (.*);
  host_uart #(.BIT(16)) u_host (.i_clk(i_clk), .i_txd(o_isp_txd),
    .o_rxd(i_isp_rxd));
  initial forever #4 i_clk = ~i_clk;
  initial begin
    repeat (40000) @(posedge i_clk);
    fail_count++;
    end_of_test();
  end
  always @(posedge i_clk) if (o_data_valid === 1'b1) begin
    db.push_back(o_data_byte);
    da.push_back(o_data_addr);
  end
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Ends when o_pready is seen high; the watchdog ends it if o_pready never rises
    do @(posedge i_clk); while (o_pready !== 1'b1);
    r = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    // Registered outputs settle one edge after the write lands
    repeat (2) @(posedge i_clk);
  endtask
  task automatic st(input logic [3:0] e);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(r[5:0], {2'h3, e})
    apb(1'b1, OFS_STATUS, 32'hF);
  endtask
  task automatic tx(input string s);
    foreach (s[i]) u_host.send(s[i]);
    repeat (600) @(posedge i_clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(posedge i_clk);
    apb(1'b0, OFS_BOOT_VECT, 32'h0);
    `CHK(r, 32'h0000FFFC)
    apb(1'b0, OFS_SECURITY, 32'h0);
    `CHK(r, 32'h000000FF)
    apb(1'b0, 12'h018, 32'h0);
    `CHK({err, r}, 33'h100000000)
    $display("test registers done");
    foreach (bt[k]) begin
      apb(1'b1, OFS_BOOT_CTRL, {31'h0, bt[k][32]});
      apb(1'b1, OFS_BOOT_VECT, {16'h0, bt[k][31:16]});
      i_external_access_select_pin <= bt[k][40];
      i_program_store_strobe_pin <= bt[k][36];
      @(posedge i_clk);
      i_device_reset_pin_n <= 1'b0;
      repeat (10) @(posedge i_clk);
      `CHK(o_boot_addr, bt[k][15:0])
      `CHK(o_boot_loader, bt[k][15:0] == 16'hF800)
      `CHK(o_fetch_external, !bt[k][40])
      i_program_store_strobe_pin <= 1'b1;
      repeat (10) @(posedge i_clk);
      `CHK(o_boot_addr, bt[k][15:0])
      i_device_reset_pin_n <= 1'b1;
      repeat (10) @(posedge i_clk);
    end
    i_fetch_addr <= 16'h8000;
    i_fetch_valid <= 1'b1;
    repeat (2) @(posedge i_clk);
    `CHK(o_fetch_external, 1'b1)
    i_fetch_addr <= API_ENTRY_ADDR;
    repeat (2) @(posedge i_clk);
    `CHK(o_api_entry, 1'b1)
    i_fetch_valid <= 1'b0;
    $display("test boot done");
    tx("U");
    `CHK(u_host.got[0], CH_U)
    apb(1'b0, OFS_BAUD, 32'h0);
    `CHK(r, 32'h10)
    tx("Q:0210000055AAEF");
    `CHK({db[0], da[0], db[1], da[1]}, 48'h551000AA1001)
    st(4'h8);
    apb(1'b0, OFS_RECORD, 32'h0);
    `CHK(r, 32'h10000002)
    tx(":0210000055AAEE");
    `CHK({u_host.got[1], u_host.got[2]}, {CH_X, CH_CR})
    `CHK(u_host.got[3], CH_LF)
    st(4'h2);
    apb(1'b1, OFS_SECURITY, 32'hFE);
    `CHK({o_program_enable, o_verify_enable}, 2'h1)
    tx(":0210000055AAEF");
    `CHK(db.size(), 4)
    st(4'hC);
    apb(1'b1, OFS_SECURITY, 32'hFD);
    `CHK({o_program_enable, o_verify_enable}, 2'h0)
    apb(1'b1, OFS_SECURITY, 32'hFF);
    `CHK({o_program_enable, o_verify_enable}, 2'h3)
    tx(":0G");
    st(4'h1);
    $display("test uart done");
    end_of_test();
  end
endmodule
`default_nettype wire
